//--- rtl/txpa_device.sv
// Device end: input capture, phase-align buffers, encoder/shifter handoff.
// Assumes link clocks, phase reset and word sync come from other clock domains; two-stage synchronised.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
module txpa_device
    import txpa_pkg::*;
#(
    parameter int DEPTH = TXPA_DEPTH
) (
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    txpa_if.dev               link,
    output logic [1:0]        enc_valid_out,
    output logic [1:0]        enc_mode_out,
    output logic [7:0]        enc_char_a_out,
    output logic [7:0]        enc_char_b_out,
    output logic [1:0]        enc_ctl_a_out,
    output logic [1:0]        enc_ctl_b_out,
    output logic [9:0]        raw_char_a_out,
    output logic [9:0]        raw_char_b_out,
    output logic              bypass_out,
    output logic              realign_out,
    output logic [4:0]        pll_mult_out
);
    typedef struct packed {
        logic [2:0]  ref_s;
        logic [2:0]  own_s;
        logic [2:0]  cha_s;
        logic [1:0]  rst_s;
        logic [1:0]  rst_cnt;
        logic        realign;
        logic [2:0]  wsync_s;
        logic [1:0][9:0] cap;
        logic [1:0][DEPTH-1:0][9:0] buf_q;
        logic [1:0][1:0] wp;
        logic [1:0][1:0] rp;
        logic [1:0][2:0] fill;
        logic [1:0]  err;
        logic [1:0]  vld;
        logic [1:0][9:0] outc;
    } txpa_dev_t;

    txpa_dev_t st;
    txpa_dev_t next_st;

    logic [1:0] cap_edge;
    logic       ref_rise;
    logic       ref_fall;
    logic       half;
    logic       bypass;
    logic       rd_edge;

    function automatic logic [9:0] txpa_word(input logic [1:0] ctl,
                                             input logic [7:0] chr);
        return {ctl, chr}; // R3
    endfunction

    // Data pins assumed stable around the capture edge, setup held by host
    assign half     = link.pll_rate_sel;
    assign bypass   = (link.tx_clock_source_sel == TXPA_SEL_REF) && !half; // R9
    assign ref_rise = st.ref_s[1] & ~st.ref_s[2];
    assign ref_fall = ~st.ref_s[1] & st.ref_s[2];
    assign rd_edge  = ref_rise | (half & ref_fall); // R12

    always_comb begin
        // R13
        case (link.tx_clock_source_sel)
            TXPA_SEL_OWN: cap_edge = {2{st.own_s[1] & ~st.own_s[2]}};
            TXPA_SEL_CHA: cap_edge = {2{st.cha_s[1] & ~st.cha_s[2]}};
            default:      cap_edge = {2{ref_rise | (half & ref_fall)}}; // R12
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.ref_s = {st.ref_s[1:0], link.reference_clk};
        next_st.own_s = {st.own_s[1:0], link.chan_tx_input_clk};
        next_st.cha_s = {st.cha_s[1:0], link.chan_a_tx_input_clk};
        next_st.rst_s = {st.rst_s[0], link.tx_phase_reset_n}; // R17
        next_st.wsync_s = {st.wsync_s[1:0], link.word_sync_req};
        next_st.vld = 2'h0;
        if (ref_rise) begin
            if (!st.rst_s[1]) begin
                if (st.rst_cnt != TXPA_RST_LOW_MIN)
                    next_st.rst_cnt = st.rst_cnt + 2'h1; // R17
            end else begin
                next_st.rst_cnt = 2'h0;
            end
        end
        // R4 R5 R8
        next_st.realign = !bypass && (st.rst_cnt == TXPA_RST_LOW_MIN)
                          && !st.rst_s[1];
        for (int c = 0; c < 2; c++) begin
            if (cap_edge[c]) begin
                next_st.cap[c] = (c == 0) ?
                    txpa_word(link.tx_char_control_a, link.chan_a_tx_char) :
                    txpa_word(link.tx_char_control_b, link.chan_b_tx_char); // R1
            end
            if (bypass) begin
                // R9
                if (cap_edge[c]) begin
                    next_st.outc[c] = next_st.cap[c];
                    next_st.vld[c]  = 1'b1;
                end
            end else if (st.realign) begin
                // R4 R6 R7: recentre, dropping buffered characters
                next_st.wp[c]   = TXPA_RD_START;
                next_st.rp[c]   = 2'h0;
                next_st.fill[c] = {1'b0, TXPA_RD_START};
                next_st.err[c]  = 1'b0; // R16
            end else begin
                // R5: fixed write and read pacing
                if (cap_edge[c]) begin
                    next_st.buf_q[c][st.wp[c]] = st.cap[c];
                    next_st.wp[c] = st.wp[c] + 2'h1;
                end
                if (rd_edge) begin
                    next_st.outc[c] = st.buf_q[c][st.rp[c]];
                    next_st.vld[c]  = 1'b1;
                    next_st.rp[c]   = st.rp[c] + 2'h1;
                end
                // Clear first so a slip in the same cycle still sets
                if (st.wsync_s[1] & ~st.wsync_s[2]) begin
                    next_st.err[c] = 1'b0; // R16
                end
                if (cap_edge[c] && !rd_edge) begin
                    if (st.fill[c] == 3'(DEPTH)) next_st.err[c] = 1'b1; // R16
                    else next_st.fill[c] = st.fill[c] + 3'h1;
                end else if (!cap_edge[c] && rd_edge) begin
                    if (st.fill[c] == 3'h0) next_st.err[c] = 1'b1; // R16
                    else next_st.fill[c] = st.fill[c] - 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign enc_valid_out  = st.vld;
    assign enc_mode_out   = link.tx_encoding_mode;
    // R2: encoder on uses byte as character value
    assign enc_char_a_out = st.outc[0][7:0];
    assign enc_char_b_out = st.outc[1][7:0];
    assign enc_ctl_a_out  = st.outc[0][9:8];
    assign enc_ctl_b_out  = st.outc[1][9:8];
    assign raw_char_a_out = st.outc[0];
    assign raw_char_b_out = st.outc[1];
    assign bypass_out     = bypass;
    assign realign_out    = st.realign;
    assign pll_mult_out   = half ? TXPA_MULT_HALF : TXPA_MULT_FULL; // R14
    assign link.tx_error_flag = st.err;
endmodule

//--- common/txpa_pkg.sv
// Package for the transmit input capture and phase-align pair.
// Assumes both ends run on one 25 MHz system clock; link clocks are sampled.
// Functional notes
// R1 - Capture characters on selected input clock rise
// R2 - Encoder on: byte is character value
// R3 - Encoder off: byte plus control form 10 bits
// R4 - Phase reset low lets buffers realign
// R5 - Phase reset high freezes phase, normal run
// R6 - Half-rate reference: reset only clears faults (code also recentres the buffer pointers on realign)
// R7 - Realignment may add or drop characters
// R8 - Host holds reset low two reference rises
// R9 - Both selects low: bypass, ignore reset
// R10 - Host asserts reset at initialization
// R11 - Reset only after clock and lock time
// R12 - Half rate samples on both reference edges
// R13 - Clock select: reference, own, channel A
// R14 - Rate select: multiply by 20 or 10
// R15 - Host avoids per-channel clocks with half rate
// R16 - Buffer slip raises sticky error flag
// R17 - Phase reset synchronised, low samples counted
package txpa_pkg;
    localparam int TXPA_CHAR_W = 8;
    localparam int TXPA_CTL_W = 2;
    localparam int TXPA_RAW_W = 10;
    localparam int TXPA_DEPTH = 4;
    localparam int TXPA_PTR_W = 2;
    localparam logic [1:0] TXPA_SEL_REF = 2'h0;
    localparam logic [1:0] TXPA_SEL_OWN = 2'h1;
    localparam logic [1:0] TXPA_SEL_CHA = 2'h2;
    localparam logic [1:0] TXPA_MODE_RAW = 2'h0;
    localparam logic [4:0] TXPA_MULT_HALF = 5'h14;
    localparam logic [4:0] TXPA_MULT_FULL = 5'h0A;
    localparam logic [1:0] TXPA_RST_LOW_MIN = 2'h2;
    localparam logic [1:0] TXPA_RD_START = 2'h2;
    localparam logic [3:0] TXPA_LINK_DIV = 4'h4;
    localparam logic [3:0] TXPA_WSYNC_LEN = 4'hF;
    localparam logic [3:0] TXPA_INIT_WAIT = 4'hF;
    localparam logic [1:0] TXPA_IRQ_MASK_RST = 2'h0;
    localparam logic [1:0] TXPA_ADDR_CTRL = 2'h0;
    localparam logic [1:0] TXPA_ADDR_DATA = 2'h1;
    localparam logic [1:0] TXPA_ADDR_STAT = 2'h2;
    localparam logic [1:0] TXPA_ADDR_MASK = 2'h3;
endpackage

//--- common/txpa_if.sv
// Interface joining the host end and the device end.
// Assumes both ends sample every signal with their own system clock.
`timescale 1ns/1ps
interface txpa_if;
    logic       reference_clk;
    logic       chan_tx_input_clk;
    logic       chan_a_tx_input_clk;
    logic [7:0] chan_a_tx_char;
    logic [7:0] chan_b_tx_char;
    logic [1:0] tx_char_control_a;
    logic [1:0] tx_char_control_b;
    logic       tx_phase_reset_n;
    logic [1:0] tx_clock_source_sel;
    logic       pll_rate_sel;
    logic [1:0] tx_encoding_mode;
    logic       word_sync_req;
    logic [1:0] tx_error_flag;
    modport host (
        output reference_clk, chan_tx_input_clk, chan_a_tx_input_clk,
        output chan_a_tx_char, chan_b_tx_char,
        output tx_char_control_a, tx_char_control_b, tx_phase_reset_n,
        output tx_clock_source_sel, pll_rate_sel, tx_encoding_mode,
        output word_sync_req,
        input  tx_error_flag
    );
    modport dev (
        input  reference_clk, chan_tx_input_clk, chan_a_tx_input_clk,
        input  chan_a_tx_char, chan_b_tx_char,
        input  tx_char_control_a, tx_char_control_b, tx_phase_reset_n,
        input  tx_clock_source_sel, pll_rate_sel, tx_encoding_mode,
        input  word_sync_req,
        output tx_error_flag
    );
endinterface

//--- rtl/txpa_host.sv
// Host end: makes link clocks by division, drives characters and reset.
// Assumes a plain register port from software on the same clock.
`timescale 1ns/1ps
module txpa_host
    import txpa_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    txpa_if.host             link,
    input  wire logic [1:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [31:0]      rdata_out,
    output logic             irq_out
);
    typedef struct packed {
        logic [3:0]  div;
        logic        lclk;
        logic [3:0]  init;
        logic [1:0]  rst_hold;
        logic        rst_n;
        logic [1:0]  csel;
        logic        rate;
        logic [1:0]  mode;
        logic [9:0]  a_word;
        logic [9:0]  b_word;
        logic        wsync;
        logic [1:0]  err_s0;
        logic [1:0]  err_s1;
        logic [1:0]  stat;
        logic [1:0]  mask;
        logic [31:0] rdata;
    } txpa_host_t;

    txpa_host_t st;
    txpa_host_t next_st;
    logic       do_reset;

    always_comb begin
        next_st = st;
        do_reset = 1'b0;
        next_st.div = st.div + 4'h1;
        if (st.div == TXPA_LINK_DIV - 4'h1) begin
            next_st.div  = 4'h0;
            next_st.lclk = ~st.lclk;
        end
        next_st.err_s0 = link.tx_error_flag;
        next_st.err_s1 = st.err_s0;
        next_st.rdata  = 32'h0;
        next_st.wsync  = 1'b0;
        if (wr_in) begin
            case (addr_in)
                TXPA_ADDR_CTRL: begin
                    // R15: half rate only with reference capture
                    next_st.csel = wdata_in[1:0];
                    next_st.rate = wdata_in[2] &&
                                   (wdata_in[1:0] == TXPA_SEL_REF);
                    next_st.mode = wdata_in[4:3];
                    do_reset     = wdata_in[5];
                    next_st.wsync = wdata_in[6];
                end
                TXPA_ADDR_DATA: begin
                    next_st.a_word = wdata_in[9:0];
                    next_st.b_word = wdata_in[25:16];
                end
                TXPA_ADDR_MASK: next_st.mask = wdata_in[1:0];
                default: ;
            endcase
        end
        if (rd_in) begin
            case (addr_in)
                TXPA_ADDR_CTRL: next_st.rdata = {25'h0, 1'b0, 1'b0,
                    st.mode, st.rate, st.csel};
                TXPA_ADDR_DATA: next_st.rdata = {6'h0, st.b_word,
                    6'h0, st.a_word};
                TXPA_ADDR_STAT: next_st.rdata = {30'h0, st.stat};
                TXPA_ADDR_MASK: next_st.rdata = {30'h0, st.mask};
                default: next_st.rdata = 32'h0;
            endcase
        end
        // Set wins over read clear
        if (rd_in && addr_in == TXPA_ADDR_STAT)
            next_st.stat = st.err_s1;
        else
            next_st.stat = st.stat | st.err_s1;
        if (st.init != 4'h0) next_st.init = st.init - 4'h1;
        // R10 R11: one reset after init wait, more on request
        if (st.init == 4'h1 || do_reset) next_st.rst_hold = 2'h3;
        if (st.rst_hold != 2'h0 && st.div == 4'h0 && st.lclk)
            next_st.rst_hold = st.rst_hold - 2'h1;
        next_st.rst_n = (next_st.rst_hold == 2'h0); // R8
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st <= '0;
            st.init <= TXPA_INIT_WAIT;
            st.mask <= TXPA_IRQ_MASK_RST;
            st.rst_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign link.reference_clk       = st.lclk;
    assign link.chan_tx_input_clk   = st.lclk;
    assign link.chan_a_tx_input_clk = st.lclk;
    assign link.chan_a_tx_char      = st.a_word[7:0];
    assign link.chan_b_tx_char      = st.b_word[7:0];
    assign link.tx_char_control_a   = st.a_word[9:8];
    assign link.tx_char_control_b   = st.b_word[9:8];
    assign link.tx_phase_reset_n    = st.rst_n;
    assign link.tx_clock_source_sel = st.csel;
    assign link.pll_rate_sel        = st.rate;
    assign link.tx_encoding_mode    = st.mode;
    assign link.word_sync_req       = st.wsync;
    assign rdata_out = st.rdata;
    assign irq_out   = |(st.stat & st.mask);
endmodule

//--- tb/txpa_sva.sv
// Checker on the link between the host end and the device end.
// Assumes the bench wires it to the interface signals by name.
`timescale 1ns/1ps
module txpa_sva
    import txpa_pkg::*;
(
    input wire logic       clk_in,
    input wire logic       srst_in,
    input wire logic       reference_clk,
    input wire logic       tx_phase_reset_n,
    input wire logic [1:0] tx_clock_source_sel,
    input wire logic       pll_rate_sel,
    input wire logic       word_sync_req,
    input wire logic [1:0] tx_error_flag
);
    logic [4:0] low_cnt;
    logic [1:0] rise_cnt;
    logic [2:0] byp_cnt;
    logic       ref_q;
    logic       byp;

    assign byp = (tx_clock_source_sel == TXPA_SEL_REF) && !pll_rate_sel;

    // Counters saturate so long idle spans never wrap
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            low_cnt  <= 5'h00;
            rise_cnt <= 2'h0;
            byp_cnt  <= 3'h0;
            ref_q    <= 1'b0;
        end else begin
            low_cnt  <= tx_phase_reset_n ? 5'h00 : low_cnt + {4'h0, ~&low_cnt};
            rise_cnt <= rise_cnt + {1'b0, reference_clk && !ref_q && ~&rise_cnt};
            byp_cnt  <= !byp ? 3'h0 : byp_cnt + {2'h0, ~&byp_cnt};
            ref_q    <= reference_clk;
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);

    a_rate_forced_low:
    assert property ((tx_clock_source_sel != TXPA_SEL_REF) |-> !pll_rate_sel)
        else $error("half rate with a channel clock selected");
    a_reset_low_long:
    assert property ($rose(tx_phase_reset_n) |-> low_cnt >= 5'h10)
        else $error("phase reset low too short");
    a_init_reset:
    assert property ($fell(srst_in) |-> ##[0:200] !tx_phase_reset_n)
        else $error("no phase reset at initialization");
    a_reset_after_clk:
    assert property ($fell(tx_phase_reset_n) |-> rise_cnt != 2'h0)
        else $error("phase reset before reference clock ran");
    a_reset_clears_err:
    assert property ($fell(tx_phase_reset_n) |-> ##[1:30]
        (tx_error_flag == 2'h0))
        else $error("phase reset left error flag set");
    a_wsync_clears_err:
    assert property ($rose(word_sync_req) |-> ##[1:40] (tx_error_flag == 2'h0))
        else $error("word sync left error flag set");
    a_bypass_no_err:
    assert property ((byp_cnt == 3'h7 && $past(tx_error_flag) == 2'h0)
        |-> tx_error_flag == 2'h0)
        else $error("error flag raised in bypass");
    a_ref_clk_half:
    assert property ($rose(reference_clk) |-> reference_clk[*4] ##1
        !reference_clk)
        else $error("reference clock high phase wrong");
endmodule

//--- tb/tx_input_phase_align_tb.sv
// Bench driving the host register port and watching the device outputs.
// Assumes one 25 MHz clock serves both ends of the link.
`timescale 1ns/1ps
module tx_input_phase_align_tb
    import txpa_pkg::*;
    ;
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic [1:0]  addr_in = 2'h0;
    logic [31:0] wdata_in = 32'h0;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic [31:0] rdata_out;
    logic        irq_out;
    logic [1:0]  enc_valid_out, enc_mode_out, enc_ctl_a_out, enc_ctl_b_out;
    logic [7:0]  enc_char_a_out, enc_char_b_out;
    logic [9:0]  raw_char_a_out, raw_char_b_out;
    logic        bypass_out, realign_out;
    logic [4:0]  pll_mult_out;
    logic [31:0] d;
    int          num_errors = 0;
    int          num_checks = 0;

    always #20 clk_in = ~clk_in;

    txpa_if link_if ();
    txpa_host txpa_host_inst (.clk_in(clk_in), .srst_in(srst_in),
        .link(link_if), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .irq_out(irq_out));
    txpa_device txpa_device_inst (.clk_in(clk_in), .srst_in(srst_in),
        .link(link_if), .enc_valid_out(enc_valid_out),
        .enc_mode_out(enc_mode_out), .enc_char_a_out(enc_char_a_out),
        .enc_char_b_out(enc_char_b_out), .enc_ctl_a_out(enc_ctl_a_out),
        .enc_ctl_b_out(enc_ctl_b_out), .raw_char_a_out(raw_char_a_out),
        .raw_char_b_out(raw_char_b_out), .bypass_out(bypass_out),
        .realign_out(realign_out), .pll_mult_out(pll_mult_out));
    txpa_sva txpa_sva_inst (.clk_in(clk_in), .srst_in(srst_in),
        .reference_clk(link_if.reference_clk),
        .tx_phase_reset_n(link_if.tx_phase_reset_n),
        .tx_clock_source_sel(link_if.tx_clock_source_sel),
        .pll_rate_sel(link_if.pll_rate_sel),
        .word_sync_req(link_if.word_sync_req),
        .tx_error_flag(link_if.tx_error_flag));

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // One idle edge between strobes keeps each strobe a single assignment
    task automatic wr(input logic [1:0] a, input logic [31:0] v);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= v;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [31:0] v);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1 v = rdata_out;
    endtask

    function automatic logic [31:0] cw(input logic [1:0] sel,
        input logic rate, input logic [1:0] mode, input logic prst,
        input logic ws);
        return {25'h0, ws, prst, mode, rate, sel};
    endfunction

    task automatic wait_lvl(input logic lvl, output logic seen);
        seen = !lvl;
        for (int i = 0; i < 60 && seen !== lvl; i++) begin
            @(posedge clk_in);
            #1 seen = realign_out;
        end
    endtask

    task automatic t_regs;
        rd(TXPA_ADDR_CTRL, d);
        check("ctrl", 32'h0, d);
        rd(TXPA_ADDR_MASK, d);
        check("mask", {30'h0, TXPA_IRQ_MASK_RST}, d);
        wr(TXPA_ADDR_MASK, 32'h3);
        rd(TXPA_ADDR_MASK, d);
        check("mask", 32'h3, d);
        rd(TXPA_ADDR_STAT, d);
        check("status", 32'h0, d);
        check("irq", 1'b0, irq_out);
    endtask

    task automatic t_rate;
        for (int r = 0; r < 2; r++) begin
            wr(TXPA_ADDR_CTRL, cw(TXPA_SEL_REF, r[0], 2'h1, 1'b0, 1'b0));
            cyc(8);
            check("mult", r ? TXPA_MULT_HALF : TXPA_MULT_FULL,
                  pll_mult_out);
            check("bypass", !r[0], bypass_out);
        end
        // Invalid pairing: the rate must fall back to full
        wr(TXPA_ADDR_CTRL, cw(TXPA_SEL_OWN, 1'b1, 2'h1, 1'b0, 1'b0));
        cyc(8);
        check("mult", TXPA_MULT_FULL, pll_mult_out);
        check("bypass", 1'b0, bypass_out);
    endtask

    task automatic t_realign(input logic [1:0] sel, input logic exp);
        logic seen;
        wr(TXPA_ADDR_CTRL, cw(sel, 1'b0, TXPA_MODE_RAW, 1'b1, 1'b0));
        cyc(2);
        #1 check("reset pin", 1'b0, link_if.tx_phase_reset_n);
        wait_lvl(1'b1, seen);
        check("realign", exp, seen);
        cyc(40);
        wr(TXPA_ADDR_CTRL, cw(sel, 1'b0, TXPA_MODE_RAW, 1'b0, 1'b0));
        wait_lvl(1'b0, seen);
        check("realign end", 1'b0, seen);
    endtask

    task automatic t_cap(input logic [1:0] sel, input logic rate,
        input logic [1:0] mode, input logic [9:0] va, input logic [9:0] vb);
        logic [1:0] got;
        got = 2'h0;
        wr(TXPA_ADDR_CTRL, cw(sel, rate, mode, 1'b0, 1'b0));
        wr(TXPA_ADDR_DATA, {6'h0, vb, 6'h0, va});
        for (int i = 0; i < 300 && got != 2'h3; i++) begin
            @(posedge clk_in);
            #1;
            if (enc_valid_out[0] && (mode == TXPA_MODE_RAW ? raw_char_a_out
                == va : {enc_ctl_a_out, enc_char_a_out} == va))
                got[0] = 1'b1;
            if (enc_valid_out[1] && (mode == TXPA_MODE_RAW ? raw_char_b_out
                == vb : {enc_ctl_b_out, enc_char_b_out} == vb))
                got[1] = 1'b1;
        end
        check("capture", 2'h3, got);
        check("mode", mode, enc_mode_out);
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #800000;
        num_errors++;
        $display("Error watchdog expected done seen hang");
        wrap_up();
    end

    initial begin
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        cyc(300);
        t_regs();
        t_rate();
        t_realign(TXPA_SEL_OWN, 1'b1);
        t_cap(TXPA_SEL_OWN, 1'b0, 2'h1, 10'h1C3, 10'h23C);
        t_realign(TXPA_SEL_CHA, 1'b1);
        t_cap(TXPA_SEL_CHA, 1'b0, 2'h2, 10'h0F0, 10'h30F);
        t_realign(TXPA_SEL_REF, 1'b0);
        t_cap(TXPA_SEL_REF, 1'b0, TXPA_MODE_RAW, 10'h3A5, 10'h15A);
        t_cap(TXPA_SEL_REF, 1'b1, 2'h3, 10'h2E7, 10'h118);
        wr(TXPA_ADDR_CTRL, cw(TXPA_SEL_OWN, 1'b0, 2'h1, 1'b0, 1'b1));
        cyc(40);
        check("error flag", 2'h0, link_if.tx_error_flag);
        wrap_up();
    end
endmodule
